// >>> core/channel_clock_divider_pair.sv
// channel clock divider: two cascaded stages, APB register slave
// assumes dist_clk and resync_in arrive asynchronously and are far
// slower than mclk; the distribution clock is sampled, not used as a clock
//
// Overview of operation
// - second stage low for low count plus one
// - second stage high for high count plus one
// - zero count gives one cycle; counts reset zero
// - phase offsets: second upper, first lower nibble
// - second bypass idles counter, passes input clock
// - first bypass idles counter, passes input clock
// - ignore-resync bit masks chip resync for both
// - force level applies only with ignore-resync set
// - second stage starts at its start level
// - first stage starts at its start level
// - duty correction on unless disable bit set
// - first stage low upper, high lower nibble
//
// Design decision made here: the APB slave port.
`timescale 1ns/10ps
module channel_clock_divider_pair
   import clkdiv_pkg::*;
(
   input  wire logic              mclk,
   input  wire logic              arst_n,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [DATA_W-1:0] pwdata,
   output logic      [DATA_W-1:0] prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              dist_clk,
   input  wire logic              resync_in,
   output logic                   chan_out
);

   // configuration registers
   logic [REG_W-1:0] first_stage_cycle_counts;
   logic [REG_W-1:0] stage_phase_offsets;
   logic [REG_W-1:0] second_stage_cycle_counts;
   logic [REG_W-1:0] channel_divider_control;
   logic [REG_W-1:0] channel_duty_correction;
   logic [REG_W-1:0] next_first_counts;
   logic [REG_W-1:0] next_phase_offsets;
   logic [REG_W-1:0] next_second_counts;
   logic [REG_W-1:0] next_div_control;
   logic [REG_W-1:0] next_duty_corr;

   // bus answer
   logic [DATA_W-1:0] next_prdata;
   logic              next_pready;
   logic              next_pslverr;
   logic [IDX_W-1:0]  idx;
   logic              access;
   logic              hit;
   logic [REG_W-1:0]  rd_val;

   // input synchronisers
   logic [2:0] dist_sync;
   logic [2:0] resync_sync;
   logic       dist_level;
   logic       dist_rise;
   logic       dist_edge;
   logic       resync_level;
   logic       resync_evt;
   logic       next_dist_level;
   logic       next_dist_rise;
   logic       next_dist_edge;
   logic       next_resync_level;
   logic       next_resync_evt;

   // stage links and channel output
   logic first_level;
   logic first_rise;
   logic second_level;
   logic restart;
   logic ignore_resync;
   logic duty_corr_on;
   logic next_chan_out;

   // ---------------------------------------------------------------
   // APB slave: one wait state, write lands at the edge ending the pready cycle
   // ---------------------------------------------------------------
   assign idx    = paddr[ADDR_W-1:2];
   assign access = psel & penable & pready;

   always_comb begin
      hit    = 1'b1;
      rd_val = '0;
      unique case (idx)
         IDX_FIRST_COUNTS:  rd_val = first_stage_cycle_counts;
         IDX_PHASE_OFFSETS: rd_val = stage_phase_offsets;
         IDX_SECOND_COUNTS: rd_val = second_stage_cycle_counts;
         IDX_DIV_CONTROL:   rd_val = channel_divider_control;
         IDX_DUTY_CORR:     rd_val = channel_duty_correction;
         IDX_STATUS: begin
            rd_val[BIT_STAT_CHANNEL] = chan_out;
            rd_val[BIT_STAT_FIRST]   = first_level;
            rd_val[BIT_STAT_SECOND]  = second_level;
         end
         default:           hit = 1'b0;
      endcase
   end

   always_comb begin
      next_pready  = psel & penable & ~pready;
      next_pslverr = psel & penable & ~pready & ~hit;
      next_prdata  = prdata;
      if (psel && penable && !pready) begin
         next_prdata = (!pwrite && hit) ? {{(DATA_W-REG_W){1'b0}}, rd_val} : '0;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         prdata  <= '0;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         prdata  <= next_prdata;
         pready  <= next_pready;
         pslverr <= next_pslverr;
      end
   end

   always_comb begin
      next_first_counts  = first_stage_cycle_counts;
      next_phase_offsets = stage_phase_offsets;
      next_second_counts = second_stage_cycle_counts;
      next_div_control   = channel_divider_control;
      next_duty_corr     = channel_duty_correction;
      if (access && pwrite) begin
         unique case (idx)
            IDX_FIRST_COUNTS:  next_first_counts  = pwdata[REG_W-1:0];
            IDX_PHASE_OFFSETS: next_phase_offsets = pwdata[REG_W-1:0];
            IDX_SECOND_COUNTS: next_second_counts = pwdata[REG_W-1:0];
            IDX_DIV_CONTROL:   next_div_control   = pwdata[REG_W-1:0] & CONTROL_MASK;
            IDX_DUTY_CORR:     next_duty_corr     = pwdata[REG_W-1:0] & DUTY_CORR_MASK;
            default: begin
               next_first_counts = first_stage_cycle_counts;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         first_stage_cycle_counts  <= RST_FIRST_COUNTS;
         stage_phase_offsets       <= RST_PHASE_OFFSETS;
         second_stage_cycle_counts <= RST_SECOND_COUNTS;
         channel_divider_control   <= RST_DIV_CONTROL;
         channel_duty_correction   <= RST_DUTY_CORR;
      end else begin
         first_stage_cycle_counts  <= next_first_counts;
         stage_phase_offsets       <= next_phase_offsets;
         second_stage_cycle_counts <= next_second_counts;
         channel_divider_control   <= next_div_control;
         channel_duty_correction   <= next_duty_corr;
      end
   end

   // ---------------------------------------------------------------
   // three-flop sampling of the distribution clock and resync pin
   // ---------------------------------------------------------------
   always_comb begin
      next_dist_level   = dist_level;
      next_dist_rise    = 1'b0;
      next_dist_edge    = 1'b0;
      next_resync_level = resync_level;
      next_resync_evt   = 1'b0;
      // a change counts once stages two and three agree
      if (dist_sync[1] == dist_sync[2]) begin
         next_dist_level = dist_sync[2];
         next_dist_rise  = dist_sync[2] & ~dist_level;
         next_dist_edge  = dist_sync[2] ^ dist_level;
      end
      if (resync_sync[1] == resync_sync[2]) begin
         next_resync_level = resync_sync[2];
         next_resync_evt   = resync_sync[2] & ~resync_level;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         dist_sync    <= 3'h0;
         resync_sync  <= 3'h0;
         dist_level   <= 1'b0;
         dist_rise    <= 1'b0;
         dist_edge    <= 1'b0;
         resync_level <= 1'b0;
         resync_evt   <= 1'b0;
      end else begin
         dist_sync    <= {dist_sync[1:0], dist_clk};
         resync_sync  <= {resync_sync[1:0], resync_in};
         dist_level   <= next_dist_level;
         dist_rise    <= next_dist_rise;
         dist_edge    <= next_dist_edge;
         resync_level <= next_resync_level;
         resync_evt   <= next_resync_evt;
      end
   end

   // ---------------------------------------------------------------
   // cascaded stages
   // ---------------------------------------------------------------
   assign ignore_resync = channel_divider_control[BIT_IGNORE_RESYNC];
   assign restart       = resync_evt & ~ignore_resync;
   assign duty_corr_on  = ~channel_duty_correction[BIT_DUTY_CORRECTION_DISABLE];

   divider_stage u_first_stage (
      .mclk         (mclk),
      .arst_n       (arst_n),
      .in_level     (dist_level),
      .in_rise      (dist_rise),
      .bypass       (channel_divider_control[BIT_BYPASS_FIRST]),
      .restart      (restart),
      .start_high   (channel_divider_control[BIT_START_FIRST]),
      .low_count    (first_stage_cycle_counts[HI_NIB_MSB:HI_NIB_LSB]),
      .high_count   (first_stage_cycle_counts[LO_NIB_MSB:LO_NIB_LSB]),
      .phase_offset (stage_phase_offsets[LO_NIB_MSB:LO_NIB_LSB]),
      .out_level    (first_level),
      .out_rise     (first_rise)
   );

   // second stage runs on mclk and steps on rising edges of the first stage output
   divider_stage u_second_stage (
      .mclk         (mclk),
      .arst_n       (arst_n),
      .in_level     (first_level),
      .in_rise      (first_rise),
      .bypass       (channel_divider_control[BIT_BYPASS_SECOND]),
      .restart      (restart),
      .start_high   (channel_divider_control[BIT_START_SECOND]),
      .low_count    (second_stage_cycle_counts[HI_NIB_MSB:HI_NIB_LSB]),
      .high_count   (second_stage_cycle_counts[LO_NIB_MSB:LO_NIB_LSB]),
      .phase_offset (stage_phase_offsets[HI_NIB_MSB:HI_NIB_LSB]),
      .out_level    (second_level),
      .out_rise     ()
   );

   // ---------------------------------------------------------------
   // channel output: force, duty correction retiming
   // ---------------------------------------------------------------
   always_comb begin
      next_chan_out = chan_out;
      if (ignore_resync) begin
         // force level only takes hold with resync ignored
         next_chan_out = channel_divider_control[BIT_FORCE_HIGH];
      end else if (duty_corr_on) begin
         // realign output changes to input clock edges
         if (dist_edge) begin
            next_chan_out = second_level;
         end
      end else begin
         next_chan_out = second_level;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         chan_out <= 1'b0;
      end else begin
         chan_out <= next_chan_out;
      end
   end

endmodule

// >>> core/clkdiv_pkg.sv
// constants for the two-stage channel clock divider
// shared by the channel top and its stage module
package clkdiv_pkg;

   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int IDX_W  = 10;
   localparam int REG_W  = 8;
   localparam int CNT_W  = 4;

   // register indices; byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_FIRST_COUNTS  = 10'h19e;
   localparam logic [IDX_W-1:0] IDX_PHASE_OFFSETS = 10'h19f;
   localparam logic [IDX_W-1:0] IDX_SECOND_COUNTS = 10'h1a0;
   localparam logic [IDX_W-1:0] IDX_DIV_CONTROL   = 10'h1a1;
   localparam logic [IDX_W-1:0] IDX_DUTY_CORR     = 10'h1a2;
   localparam logic [IDX_W-1:0] IDX_STATUS        = 10'h1a3;

   // nibble fields of the count and offset registers
   localparam int HI_NIB_MSB = 7;
   localparam int HI_NIB_LSB = 4;
   localparam int LO_NIB_MSB = 3;
   localparam int LO_NIB_LSB = 0;

   // divider control bits
   localparam int BIT_BYPASS_SECOND = 5;
   localparam int BIT_BYPASS_FIRST  = 4;
   localparam int BIT_IGNORE_RESYNC = 3;
   localparam int BIT_FORCE_HIGH    = 2;
   localparam int BIT_START_SECOND  = 1;
   localparam int BIT_START_FIRST   = 0;

   // duty correction bit
   localparam int BIT_DUTY_CORRECTION_DISABLE = 0;
   localparam logic [REG_W-1:0] DUTY_CORR_MASK = 8'h01;
   localparam logic [REG_W-1:0] CONTROL_MASK   = 8'h3f;

   // status bits
   localparam int BIT_STAT_CHANNEL = 0;
   localparam int BIT_STAT_FIRST   = 1;
   localparam int BIT_STAT_SECOND  = 2;

   // reset values
   localparam logic [REG_W-1:0] RST_FIRST_COUNTS  = 8'h00;
   localparam logic [REG_W-1:0] RST_PHASE_OFFSETS = 8'h00;
   localparam logic [REG_W-1:0] RST_SECOND_COUNTS = 8'h00;
   localparam logic [REG_W-1:0] RST_DIV_CONTROL   = 8'h00;
   localparam logic [REG_W-1:0] RST_DUTY_CORR     = 8'h00;
   localparam logic [CNT_W-1:0] CNT_ZERO          = 4'h0;
   localparam logic [CNT_W-1:0] CNT_ONE           = 4'h1;

endpackage

// >>> core/divider_stage.sv
// one programmable low/high divider stage with bypass
// assumes in_rise is a one-cycle pulse at each rising edge of in_level
`timescale 1ns/10ps
module divider_stage
   import clkdiv_pkg::*;
(
   input  wire logic             mclk,
   input  wire logic             arst_n,
   input  wire logic             in_level,
   input  wire logic             in_rise,
   input  wire logic             bypass,
   input  wire logic             restart,
   input  wire logic             start_high,
   input  wire logic [CNT_W-1:0] low_count,
   input  wire logic [CNT_W-1:0] high_count,
   input  wire logic [CNT_W-1:0] phase_offset,
   output logic                  out_level,
   output logic                  out_rise
);

   logic             level;
   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] hold;
   logic             next_level;
   logic [CNT_W-1:0] next_cnt;
   logic [CNT_W-1:0] next_hold;
   logic             div_rise;
   logic [CNT_W-1:0] limit;

   always_comb begin
      next_level = level;
      next_cnt   = cnt;
      next_hold  = hold;
      div_rise   = 1'b0;
      limit      = level ? high_count : low_count;
      if (bypass || restart) begin
         // counting held idle; restart from start level after offset
         next_level = start_high;
         next_cnt   = CNT_ZERO;
         next_hold  = phase_offset;
      end else if (in_rise) begin
         if (hold != CNT_ZERO) begin
            next_hold = hold - CNT_ONE;
         end else if (cnt >= limit) begin
            // a count lowered mid-phase ends the phase at the next input rise, no wrap
            // zero count gives a one-cycle phase
            next_level = ~level;
            next_cnt   = CNT_ZERO;
            div_rise   = ~level;
         end else begin
            next_cnt = cnt + CNT_ONE;
         end
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         level <= 1'b0;
         cnt   <= CNT_ZERO;
         hold  <= CNT_ZERO;
      end else begin
         level <= next_level;
         cnt   <= next_cnt;
         hold  <= next_hold;
      end
   end

   // bypass routes the input clock straight through
   assign out_level = bypass ? in_level : level;
   assign out_rise  = bypass ? in_rise : div_rise;

endmodule

// >>> sim/channel_clock_divider_pair_assertions.sv
// assertions on the channel divider top ports
// bound to every instance of channel_clock_divider_pair
`timescale 1ns/10ps
module channel_clock_divider_pair_assertions
   import clkdiv_pkg::*;
(
   input wire logic              mclk,
   input wire logic              arst_n,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [DATA_W-1:0] pwdata,
   input wire logic [DATA_W-1:0] prdata,
   input wire logic              pready,
   input wire logic              pslverr,
   input wire logic              dist_clk,
   input wire logic              resync_in,
   input wire logic              chan_out
);
   logic [REG_W-1:0] ctl;
   logic [4:0]       age;
   logic             acc;
   logic             wr_ctl;
   logic             mapped;
   assign acc    = psel && penable && !pready;
   assign wr_ctl = psel && penable && pready && pwrite && paddr[11:2] == IDX_DIV_CONTROL;
   assign mapped = paddr[11:2] >= IDX_FIRST_COUNTS && paddr[11:2] <= IDX_STATUS;
   // shadow of the control register, age since last write
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         ctl <= RST_DIV_CONTROL;
         age <= 5'h00;
      end else if (wr_ctl) begin
         ctl <= pwdata[REG_W-1:0];
         age <= 5'h00;
      end else if (age != 5'h1f) begin
         age <= age + 5'h01;
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);
   property p_wait_state; acc |=> pready; endproperty
   a_wait_state: assert property (p_wait_state) else $error("access not answered after one wait state");
   property p_err_map; acc |=> (pslverr == !$past(mapped)); endproperty
   a_err_map: assert property (p_err_map) else $error("error response does not match address map");
   property p_ready_pulse; pready |=> !pready; endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than one cycle");
   property p_ready_in_access; pready |-> psel && penable; endproperty
   a_ready_in_access: assert property (p_ready_in_access) else $error("ready outside access phase");
   property p_err_with_ready; pslverr |-> pready; endproperty
   a_err_with_ready: assert property (p_err_with_ready) else $error("error without ready");
   property p_upper_zero; pready |-> prdata[31:8] == 24'h000000; endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("read data upper bits not zero");
   property p_duty_read; pready && !pwrite && paddr[11:2] == IDX_DUTY_CORR |-> prdata[31:1] == '0; endproperty
   a_duty_read: assert property (p_duty_read) else $error("duty register reads undefined bits");
   property p_force; age == 5'h1f && ctl[BIT_IGNORE_RESYNC] |-> chan_out == ctl[BIT_FORCE_HIGH]; endproperty
   a_force: assert property (p_force) else $error("forced level not on channel output");
endmodule

bind channel_clock_divider_pair channel_clock_divider_pair_assertions i_chk (
   .mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .dist_clk(dist_clk), .resync_in(resync_in), .chan_out(chan_out));

// >>> sim/tb_channel_clock_divider_pair.sv
// self-checking bench for the channel clock divider pair
// drives APB, the distribution clock and resync directly
`timescale 1ns/10ps
module tb_channel_clock_divider_pair;
   import clkdiv_pkg::*;
   logic              mclk      = 1'b0;
   logic              arst_n    = 1'b0;
   logic              psel      = 1'b0;
   logic              penable   = 1'b0;
   logic              pwrite    = 1'b0;
   logic              dist_clk  = 1'b0;
   logic              resync_in = 1'b0;
   logic [ADDR_W-1:0] paddr     = '0;
   logic [DATA_W-1:0] pwdata    = '0;
   logic [DATA_W-1:0] prdata;
   logic              pready;
   logic              pslverr;
   logic              chan_out;
   logic [DATA_W-1:0] rd;
   logic              err;
   logic [31:0]       hi;
   logic [31:0]       lo;
   int                error_cnt  = 0;
   int                n_compared = 0;

   channel_clock_divider_pair i_channel_clock_divider_pair (
      .mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .dist_clk(dist_clk), .resync_in(resync_in), .chan_out(chan_out));

   initial forever #25 mclk = ~mclk;
   // distribution clock, period 20 mclk
   always begin
      repeat (10) @(posedge mclk);
      dist_clk <= ~dist_clk;
   end
   initial begin
      repeat (30000) @(posedge mclk);
      error_cnt++;
      conclude();
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [IDX_W-1:0] idx, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= {idx, 2'b00};
      pwdata  <= {24'h000000, d};
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         error_cnt++;
         conclude();
      end
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rchk(input logic [IDX_W-1:0] idx, input logic [7:0] exp, input logic experr);
      apb(1'b0, idx, 8'h00);
      check(rd, {24'h000000, exp});
      check(err, experr);
   endtask

   // one full high and low phase of chan_out, in mclk cycles
   task automatic wave(input logic [7:0] ctl, c1, c2, input logic [31:0] ehi, elo);
      int n;
      apb(1'b1, IDX_FIRST_COUNTS, c1);
      apb(1'b1, IDX_SECOND_COUNTS, c2);
      apb(1'b1, IDX_DIV_CONTROL, ctl);
      n = 0;
      hi = 0;
      lo = 0;
      repeat (200) @(posedge mclk);
      while (chan_out !== 1'b0 && n < 500) begin
         @(posedge mclk);
         n++;
      end
      while (chan_out !== 1'b1 && n < 500) begin
         @(posedge mclk);
         n++;
      end
      while (chan_out === 1'b1 && n < 500) begin
         @(posedge mclk);
         n++;
         hi++;
      end
      while (chan_out === 1'b0 && n < 500) begin
         @(posedge mclk);
         n++;
         lo++;
      end
      check(hi, ehi);
      check(lo, elo);
   endtask

   task automatic rs(input logic [7:0] ctl, c1, c2, offs, input int wt, input logic exp);
      apb(1'b1, IDX_FIRST_COUNTS, c1);
      apb(1'b1, IDX_SECOND_COUNTS, c2);
      apb(1'b1, IDX_PHASE_OFFSETS, offs);
      apb(1'b1, IDX_DIV_CONTROL, ctl);
      @(posedge mclk);
      resync_in <= 1'b1;
      repeat (wt) @(posedge mclk);
      check(chan_out, exp);
      resync_in <= 1'b0;
      repeat (20) @(posedge mclk);
   endtask

   task automatic conclude;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   initial begin
      repeat (10) @(posedge mclk);
      arst_n <= 1'b1;
      rchk(IDX_FIRST_COUNTS, 8'h00, 1'b0);
      rchk(IDX_PHASE_OFFSETS, 8'h00, 1'b0);
      rchk(IDX_SECOND_COUNTS, 8'h00, 1'b0);
      rchk(IDX_DIV_CONTROL, 8'h00, 1'b0);
      rchk(IDX_DUTY_CORR, 8'h00, 1'b0);
      apb(1'b1, IDX_DIV_CONTROL, 8'hff);
      rchk(IDX_DIV_CONTROL, 8'h3f, 1'b0);
      apb(1'b1, IDX_PHASE_OFFSETS, 8'ha5);
      rchk(IDX_PHASE_OFFSETS, 8'ha5, 1'b0);
      apb(1'b1, IDX_DUTY_CORR, 8'hff);
      rchk(IDX_DUTY_CORR, 8'h01, 1'b0);
      rchk(10'h1a4, 8'h00, 1'b1);
      rchk(10'h000, 8'h00, 1'b1);
      apb(1'b1, IDX_PHASE_OFFSETS, 8'h00);
      wave(8'h20, 8'h21, 8'h00, 32'd40, 32'd60);
      wave(8'h10, 8'h00, 8'h13, 32'd80, 32'd40);
      wave(8'h00, 8'h00, 8'h00, 32'd40, 32'd40);
      wave(8'h34, 8'h00, 8'h00, 32'd10, 32'd10);
      rs(8'h0c, 8'h00, 8'h00, 8'h00, 20, 1'b1);
      rs(8'h08, 8'h00, 8'h00, 8'h00, 20, 1'b0);
      rs(8'h12, 8'h00, 8'h33, 8'h00, 10, 1'b1);
      rs(8'h10, 8'h00, 8'h33, 8'h00, 10, 1'b0);
      rs(8'h21, 8'h33, 8'h00, 8'h00, 10, 1'b1);
      rs(8'h20, 8'h33, 8'h00, 8'h00, 10, 1'b0);
      rs(8'h12, 8'h00, 8'h33, 8'h00, 110, 1'b0);
      rs(8'h12, 8'h00, 8'h33, 8'h40, 110, 1'b1);
      apb(1'b1, IDX_DUTY_CORR, 8'h00);
      rchk(IDX_DUTY_CORR, 8'h00, 1'b0);
      wave(8'h00, 8'h00, 8'h00, 32'd40, 32'd40);
      conclude();
   end
endmodule
